// ---- tb/ccd_clock_pattern_sequencer_test.sv ----
`timescale 1ns/1ns
module ccd_clock_pattern_sequencer_test;
  import ccdseq_pkg::*;
  // shrunk geometry keeps each frame to a few thousand cycles
  localparam int LS = 3;
  localparam int LL = 6;
  localparam int PS = 4;
  localparam int PL = 8;
  localparam int CDD = 4;
  localparam int LIMIT = 40000;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic frame_start_i = 1'b0;
  logic cd_park_i = 1'b0;
  logic [1:0] mode_i = 2'h0;
  logic [1:0] cur_mode = 2'h0;
  logic cur_park = 1'b0;
  logic t1, t2, t3, t4, t3rd, b1, b2, b3, b4, b3rd, busy, lstb, pstb, t3rd_p;
  logic [3:0] hs1, hb1, hs2, hb2, hlast, rg, tv_p, hs2_p, rg_p;
  logic [7:0] hcd_p;
  logic [15:0] rows, pixels;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_lines = 0, n_pix = 0, rg_rise = 0, a_rise = 0, c_rise = 0, cd_chg = 0;
  int bad_vert = 0, bad_third = 0, bad_last = 0, bad_swap = 0, bad_park = 0;
  int s_l, s_p, s_rg, s_a, s_c, s_cd, s_rows, s_pix;

  ccdseq_timing_gen #(.LINES_SHORT(LS), .LINES_LONG(LL), .PIX_SHORT(PS), .PIX_LONG(PL), .CD_DIV(CDD)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .frame_start_i(frame_start_i), .mode_i(mode_i), .cd_park_i(cd_park_i),
    .top_vertical_phase_one_o(t1), .top_vertical_phase_two_o(t2), .top_vertical_phase_three_o(t3),
    .top_vertical_phase_four_o(t4), .top_phase_one_third_o(t3rd), .bottom_vertical_phase_one_o(b1),
    .bottom_vertical_phase_two_o(b2), .bottom_vertical_phase_three_o(b3), .bottom_vertical_phase_four_o(b4),
    .bottom_phase_one_third_o(b3rd), .horiz_storage_one_o(hs1), .horiz_barrier_one_o(hb1),
    .horiz_storage_two_o(hs2), .horiz_barrier_two_o(hb2), .last_horizontal_phase_o(hlast), .reset_gate_o(rg),
    .frame_busy_o(busy), .line_strobe_o(lstb), .pixel_strobe_o(pstb));

  ccdseq_sensor_model i_sensor (.clk_i(clk_i), .nrst_i(nrst_i), .vertical_phase_one_i(b1),
    .last_horizontal_phase_i(hlast[0]), .rows_o(rows), .pixels_o(pixels));

  // pixel clock
  always #5 clk_i = ~clk_i;

  // running monitor of edge order and lane activity; tasks read differences between snapshots
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (nrst_i) begin
      // bottom pins always carry the base vertical patterns, so edge order is judged there
      if ($countones({b1, b2, b3, b4} & ~tv_p) != $countones(~{b1, b2, b3, b4} & tv_p)) bad_vert++;
      if ((t3rd_p && !t3rd && !(b4 && !tv_p[0])) || (t3rd !== b3rd)) bad_third++;
      if ((hlast !== hs2) || ({hb1[0], hb2[0]} !== {hs1[0], hs2[0]})) bad_last++;
      // top pins are remapped only once the latched mode reaches the pins, hence the busy gate
      if (busy && ({t1, t2, t3, t4} !== (cur_mode[0] ? {b1, b4, b3, b2} : {b1, b2, b3, b4}))) bad_swap++;
      if (cur_park && cur_mode == 2'h3 && busy &&
          ({hs1[3:2], hb1[3:2], hs2[3:2], hb2[3:2], rg[3:1]} !== 11'h7FF)) bad_park++;
      if (cur_mode == 2'h2 && busy && (hb1[1] !== hs2[1])) bad_swap++;
      n_lines += lstb;
      n_pix += pstb;
      rg_rise += (rg[0] && !rg_p[0]);
      a_rise += (hs2[0] && !hs2_p[0]);
      c_rise += (hs2[2] && !hs2_p[2]);
      cd_chg += ({hs1[3:2], hb1[3:2], hs2[3:2], hb2[3:2]} != hcd_p);
    end
    tv_p = {b1, b2, b3, b4};
    t3rd_p = t3rd;
    hs2_p = hs2;
    rg_p = rg;
    hcd_p = {hs1[3:2], hb1[3:2], hs2[3:2], hb2[3:2]};
    if (cyc == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // idle levels straight after reset
  task automatic test_reset();
    check({t1, t2, t3, t4, t3rd, hs1, hb1, hs2, hb2, hlast, rg, busy}, {VEC_PARK, 1'b0, 8'hFF, 16'h0, 1'b0});
    $display("test reset done");
  endtask

  // one whole frame in mode m; expected counts follow the frame geometry, not the design
  task automatic run_frame(input logic [1:0] m, input logic park);
    int l_exp;
    int p_exp;
    l_exp = (m[0] == 1'b0) ? LS : LL;
    p_exp = (m[1] == 1'b0) ? PS : PL;
    s_l = n_lines;
    s_p = n_pix;
    s_rg = rg_rise;
    s_a = a_rise;
    s_c = c_rise;
    s_cd = cd_chg;
    s_rows = rows;
    s_pix = pixels;
    @(posedge clk_i);
    mode_i <= m;
    cd_park_i <= park;
    cur_mode <= m;
    cur_park <= park;
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    while (!busy) begin
      @(posedge clk_i);
    end
    while (busy) begin
      @(posedge clk_i);
    end
    // let the last slow-lane toggle and strobes reach the monitor
    repeat (4) @(posedge clk_i);
    check(n_lines - s_l, l_exp);
    check(rows - s_rows, l_exp);
    check(n_pix - s_p, l_exp * p_exp);
    check(pixels - s_pix, l_exp * p_exp);
    check(rg_rise - s_rg, l_exp * p_exp);
    check(a_rise - s_a, l_exp * p_exp);
    if (!park) begin
      check(c_rise - s_c, m[0] ? l_exp * p_exp / CDD : l_exp * p_exp);
    end
    if (m[0] && !park) begin
      check(cd_chg - s_cd, 2 * l_exp * p_exp / CDD);
    end
    check(bad_vert, 32'h0);
    check(bad_third, 32'h0);
    check(bad_last, 32'h0);
    check(bad_swap, 32'h0);
    check(bad_park, 32'h0);
    $display("test frame mode %0d park %0d done", m, park);
  endtask

  // reset pulled in mid-frame; pins fall back to idle at once and stay there after release
  task automatic test_mid_reset();
    @(posedge clk_i);
    mode_i <= 2'h1;
    cd_park_i <= 1'b0;
    cur_mode <= 2'h1;
    cur_park <= 1'b0;
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    repeat (200) @(posedge clk_i);
    check({busy, b1, b2, b3, b4}, {1'b1, VEC_PD});
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check({t1, t2, t3, t4, t3rd, hs1, hb1, hs2, hb2, hlast, rg, busy}, {VEC_PARK, 1'b0, 8'hFF, 16'h0, 1'b0});
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({t1, t2, t3, t4, t3rd, hs1, hb1, hs2, hb2, hlast, rg, busy}, {VEC_PARK, 1'b0, 8'hFF, 16'h0, 1'b0});
    $display("test mid reset done");
  endtask

  // reset for five cycles, then every readout mode, a parked frame and a reset in mid-run
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    test_reset();
    run_frame(2'h0, 1'b0);
    run_frame(2'h1, 1'b0);
    run_frame(2'h2, 1'b0);
    run_frame(2'h3, 1'b1);
    test_mid_reset();
    run_frame(2'h3, 1'b0);
    give_verdict();
  end
endmodule // ccd_clock_pattern_sequencer_test

// ---- tb/ccdseq_sensor_model.sv ----
`timescale 1ns/1ns
// behavioural sensor: counts rows moved into the horizontal register and pixels sent to the amplifier
module ccdseq_sensor_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic vertical_phase_one_i,
  input wire logic last_horizontal_phase_i,
  output logic [15:0] rows_o,
  output logic [15:0] pixels_o
);
  logic ph1_r;
  logic last_r;

  // edges are seen on the pixel clock, since the sensor has no timebase of its own
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph1_r <= 1'b1;
      last_r <= 1'b0;
      rows_o <= 16'h0;
      pixels_o <= 16'h0;
    end else begin
      ph1_r <= vertical_phase_one_i;
      last_r <= last_horizontal_phase_i;
      // first fall carries the dummy row merged with the first dark row, so no extra line
      if (ph1_r && !vertical_phase_one_i) rows_o <= rows_o + 16'h1;
      if (last_r && !last_horizontal_phase_i) pixels_o <= pixels_o + 16'h1;
    end
  end
endmodule // ccdseq_sensor_model

// ---- verilog/ccdseq_pkg.sv ----
// Behaviour
// RL1: drive every sensor clock pin with one of seven vertical, horizontal or reset patterns.
// RL2: sensor moves a row into the horizontal register on phase one falling edge.
// RL3: leading dummy row merges with first dark row; no separate line is expected.
// RL4: line counter runs 380 lines in quad and dual a/c, 760 otherwise.
// RL5: every vertical rising edge coincides with a falling edge in the same interval.
// RL6: phase four rises exactly when phase one drops from third level to mid.
// RL7: sensor shifts each pixel out on the last horizontal phase falling edge.
// RL8: pixel counter clocks 693 or 1386 shifts per line, by readout mode.
// RL9: last horizontal phase output repeats the phase two storage pattern of its register.
// RL10: unused c/d registers may run slower, at an integer fraction of a/b rate.
// RL11: unused c/d register clocks may instead sit statically at the off level.
// RL12: readout mode remaps top vertical phases and horizontal storage/barrier patterns.
package ccdseq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // pattern timing minima, in ns as printed
  localparam int T_LEAD_PED_NS = 4000;
  localparam int T_PD_XFER_NS = 1000;
  localparam int T_TRAIL_PED_NS = 4000;
  localparam int T_VXFER_NS = 1000;
  localparam int T_HDELAY_NS = 200;
  localparam int T_HHALF_NS = 25;
  // least times round up to whole cycles
  localparam int T_LEAD_PED_CYC = (T_LEAD_PED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PD_XFER_CYC = (T_PD_XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_TRAIL_PED_CYC = (T_TRAIL_PED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_VXFER_CYC = (T_VXFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HDELAY_CYC = (T_HDELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HHALF_CYC = (T_HHALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // frame geometry minima
  localparam int LINES_HALF = 380;
  localparam int LINES_FULL = 760;
  localparam int PIX_HALF = 693;
  localparam int PIX_FULL = 1386;
  localparam int TMR_W = 12;
  localparam int LINE_W = 10;
  localparam int PIX_W = 11;
  // vertical vector bit order {ph1, ph2, ph3, ph4}
  localparam logic [3:0] VEC_PARK = 4'h9;
  localparam logic [3:0] VEC_PD = 4'hC;
  localparam logic [1:0] STEP_LAST = 2'h3;
  localparam int REG_A = 0;
  localparam int REG_B = 1;
  localparam int REG_C = 2;
  localparam int REG_D = 3;

  typedef enum logic [1:0] {
    MODE_QUAD = 2'h0,
    MODE_DUAL_AB = 2'h1,
    MODE_DUAL_AC = 2'h2,
    MODE_SINGLE = 2'h3
  } ccdseq_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PD_LEAD = 3'h1,
    ST_PD_HIGH = 3'h2,
    ST_PD_TRAIL = 3'h3,
    ST_VSHIFT = 3'h4,
    ST_HDELAY = 3'h5,
    ST_HREAD = 3'h6
  } ccdseq_state_e;

  // four-phase line shift, each step has one rise and one fall together
  function automatic logic [3:0] vstep_vec(input logic [1:0] step);
    unique case (step)
      2'h0: vstep_vec = 4'hC;
      2'h1: vstep_vec = 4'h6;
      2'h2: vstep_vec = 4'h3;
      2'h3: vstep_vec = 4'h9;
    endcase
  endfunction
endpackage

// ---- verilog/ccdseq_rate_div.sv ----
`timescale 1ns/1ns
// divides a stream of tick pulses by DIV, giving a one-cycle enable
module ccdseq_rate_div #(
  parameter int DIV = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  output logic en_o
);
  logic [7:0] cnt_r;

  // counter restarts on each output pulse so the ratio stays an exact integer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 8'h00;
      en_o <= 1'b0;
    end else begin
      en_o <= 1'b0;
      if (tick_i) begin
        if (cnt_r == 8'(DIV - 1)) begin
          cnt_r <= 8'h00;
          en_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule // ccdseq_rate_div

// ---- verilog/ccdseq_timing_gen.sv ----
`timescale 1ns/1ns
module ccdseq_timing_gen
  import ccdseq_pkg::*;
#(
  parameter int LINES_SHORT = LINES_HALF,
  parameter int LINES_LONG = LINES_FULL,
  parameter int PIX_SHORT = PIX_HALF,
  parameter int PIX_LONG = PIX_FULL,
  parameter int CD_DIV = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic frame_start_i,
  input wire logic [1:0] mode_i,
  input wire logic cd_park_i,
  output logic top_vertical_phase_one_o,
  output logic top_vertical_phase_two_o,
  output logic top_vertical_phase_three_o,
  output logic top_vertical_phase_four_o,
  output logic top_phase_one_third_o,
  output logic bottom_vertical_phase_one_o,
  output logic bottom_vertical_phase_two_o,
  output logic bottom_vertical_phase_three_o,
  output logic bottom_vertical_phase_four_o,
  output logic bottom_phase_one_third_o,
  output logic [3:0] horiz_storage_one_o,
  output logic [3:0] horiz_barrier_one_o,
  output logic [3:0] horiz_storage_two_o,
  output logic [3:0] horiz_barrier_two_o,
  output logic [3:0] last_horizontal_phase_o,
  output logic [3:0] reset_gate_o,
  output logic frame_busy_o,
  output logic line_strobe_o,
  output logic pixel_strobe_o
);
  ccdseq_state_e st_r;
  logic [TMR_W-1:0] tmr_r;
  logic [1:0] step_r;
  logic [LINE_W-1:0] line_r;
  logic [PIX_W-1:0] pix_r;
  logic [3:0] hcnt_r;
  ccdseq_mode_e mode_r;
  logic park_r;
  logic [3:0] vec;
  logic third;
  logic p5;
  logic p6;
  logic p7;
  logic p6_d_r;
  logic half_tick;
  logic slow_en;
  logic slow_ph_r;
  logic [3:0] h1s_nxt;
  logic [3:0] h1b_nxt;
  logic [3:0] h2s_nxt;
  logic [3:0] h2b_nxt;
  logic [3:0] rg_nxt;

  localparam logic [3:0] HALF = 4'(T_HHALF_CYC);
  localparam logic [3:0] HLAST = 4'(2 * T_HHALF_CYC - 1);

  function automatic logic [LINE_W-1:0] lines_of(input ccdseq_mode_e m);
    lines_of = (m == MODE_QUAD || m == MODE_DUAL_AC) ? LINE_W'(LINES_SHORT - 1) : LINE_W'(LINES_LONG - 1);
  endfunction

  function automatic logic [PIX_W-1:0] pix_of(input ccdseq_mode_e m);
    pix_of = (m == MODE_QUAD || m == MODE_DUAL_AB) ? PIX_W'(PIX_SHORT - 1) : PIX_W'(PIX_LONG - 1);
  endfunction

  // register lanes that a mode leaves without video
  function automatic logic h_idle(input ccdseq_mode_e m, input int r);
    h_idle = (m == MODE_DUAL_AB || m == MODE_SINGLE) && (r == REG_C || r == REG_D);
  endfunction

  function automatic logic rg_idle(input ccdseq_mode_e m, input int r);
    rg_idle = ((m == MODE_DUAL_AB) && (r == REG_C || r == REG_D)) ||
              ((m == MODE_DUAL_AC) && (r == REG_B || r == REG_D)) ||
              ((m == MODE_SINGLE) && (r != REG_A));
  endfunction

  function automatic logic b_swap(input ccdseq_mode_e m, input int r);
    b_swap = (m == MODE_DUAL_AC) && (r == REG_B || r == REG_D);
  endfunction

  // sequencer: photodiode transfer, then per line a vertical shift and a pixel readout
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      step_r <= 2'h0;
      line_r <= '0;
      pix_r <= '0;
      hcnt_r <= 4'h0;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
      unique case (st_r)
        ST_IDLE: begin
          tmr_r <= '0;
          if (frame_start_i) begin
            st_r <= ST_PD_LEAD;
          end
        end
        ST_PD_LEAD: begin
          if (tmr_r == TMR_W'(T_LEAD_PED_CYC - 1)) begin
            st_r <= ST_PD_HIGH;
            tmr_r <= '0;
          end
        end
        ST_PD_HIGH: begin
          if (tmr_r == TMR_W'(T_PD_XFER_CYC - 1)) begin
            st_r <= ST_PD_TRAIL;
            tmr_r <= '0;
          end
        end
        ST_PD_TRAIL: begin
          if (tmr_r == TMR_W'(T_TRAIL_PED_CYC - 1)) begin
            st_r <= ST_VSHIFT;
            tmr_r <= '0;
            step_r <= 2'h0;
            line_r <= '0; // RL3
          end
        end
        ST_VSHIFT: begin
          if (tmr_r == TMR_W'(T_VXFER_CYC - 1)) begin
            tmr_r <= '0;
            step_r <= step_r + 2'h1;
            if (step_r == STEP_LAST) begin
              st_r <= ST_HDELAY;
            end
          end
        end
        ST_HDELAY: begin
          if (tmr_r == TMR_W'(T_HDELAY_CYC - 1)) begin
            st_r <= ST_HREAD;
            pix_r <= '0;
            hcnt_r <= 4'h0;
          end
        end
        ST_HREAD: begin
          hcnt_r <= hcnt_r + 4'h1;
          if (hcnt_r == HLAST) begin
            hcnt_r <= 4'h0;
            pix_r <= pix_r + PIX_W'(1);
            if (pix_r == pix_of(mode_r)) begin // RL8
              tmr_r <= '0;
              line_r <= line_r + LINE_W'(1);
              st_r <= (line_r == lines_of(mode_r)) ? ST_IDLE : ST_VSHIFT; // RL4
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // mode and parking are frozen for the whole frame so lanes never change mid-line
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= MODE_QUAD;
      park_r <= 1'b0;
    end else if (st_r == ST_IDLE && frame_start_i) begin
      mode_r <= ccdseq_mode_e'(mode_i); // RL12
      park_r <= cd_park_i;
    end
  end

  // base patterns; leaving the third level and raising phase four share one edge
  always_comb begin
    vec = VEC_PARK;
    third = 1'b0;
    unique case (st_r)
      ST_PD_LEAD: vec = VEC_PD;
      ST_PD_HIGH: begin
        vec = VEC_PD;
        third = 1'b1;
      end
      ST_VSHIFT: vec = vstep_vec(step_r); // RL5 RL2
      default: vec = VEC_PARK; // RL6
    endcase
    p5 = (st_r == ST_HREAD) ? (hcnt_r < HALF) : 1'b1;
    p6 = (st_r == ST_HREAD) && (hcnt_r >= HALF);
    p7 = (st_r == ST_HREAD) && (hcnt_r == 4'h0);
  end

  assign half_tick = (st_r == ST_HREAD) && (hcnt_r == 4'h0 || hcnt_r == HALF);

  // slow clock for unused lanes; costs less drive power than full rate
  ccdseq_rate_div #(
    .DIV(CD_DIV)
  ) u_cd_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(half_tick),
    .en_o(slow_en)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slow_ph_r <= 1'b1;
    end else if (slow_en) begin
      slow_ph_r <= ~slow_ph_r; // RL10
    end
  end

  // per-register lane mapping, storage and barrier swap, parking at off level
  always_comb begin
    logic s1;
    logic s2;
    logic a5;
    logic a6;
    logic a7;
    s1 = 1'b0;
    s2 = 1'b0;
    a5 = 1'b0;
    a6 = 1'b0;
    a7 = 1'b0;
    h1s_nxt = 4'h0;
    h1b_nxt = 4'h0;
    h2s_nxt = 4'h0;
    h2b_nxt = 4'h0;
    rg_nxt = 4'h0;
    a5 = park_r ? 1'b1 : ((CD_DIV == 1) ? p5 : slow_ph_r); // RL11
    a6 = park_r ? 1'b1 : ((CD_DIV == 1) ? p6 : ~slow_ph_r);
    a7 = park_r ? 1'b1 : ((CD_DIV == 1) ? p7 : slow_en);
    for (int r = 0; r < 4; r++) begin
      s1 = h_idle(mode_r, r) ? a5 : p5;
      s2 = h_idle(mode_r, r) ? a6 : p6;
      h1s_nxt[r] = s1;
      h2s_nxt[r] = s2;
      h1b_nxt[r] = b_swap(mode_r, r) ? s2 : s1; // RL12
      h2b_nxt[r] = b_swap(mode_r, r) ? s1 : s2;
      rg_nxt[r] = rg_idle(mode_r, r) ? a7 : p7;
    end
  end

  // output stage: every pin is a flop; top phases two and four swap in a/b and single modes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {bottom_vertical_phase_one_o, bottom_vertical_phase_two_o} <= 2'h2;
      {bottom_vertical_phase_three_o, bottom_vertical_phase_four_o} <= 2'h1;
      {top_vertical_phase_one_o, top_vertical_phase_two_o} <= 2'h2;
      {top_vertical_phase_three_o, top_vertical_phase_four_o} <= 2'h1;
      top_phase_one_third_o <= 1'b0;
      bottom_phase_one_third_o <= 1'b0;
      horiz_storage_one_o <= 4'hF;
      horiz_barrier_one_o <= 4'hF;
      horiz_storage_two_o <= 4'h0;
      horiz_barrier_two_o <= 4'h0;
      last_horizontal_phase_o <= 4'h0;
      reset_gate_o <= 4'h0;
    end else begin
      {bottom_vertical_phase_one_o, bottom_vertical_phase_two_o} <= vec[3:2]; // RL1
      {bottom_vertical_phase_three_o, bottom_vertical_phase_four_o} <= vec[1:0];
      bottom_phase_one_third_o <= third;
      top_phase_one_third_o <= third;
      top_vertical_phase_one_o <= vec[3];
      top_vertical_phase_three_o <= vec[1];
      if (mode_r == MODE_DUAL_AB || mode_r == MODE_SINGLE) begin
        top_vertical_phase_two_o <= vec[0]; // RL12
        top_vertical_phase_four_o <= vec[2];
      end else begin
        top_vertical_phase_two_o <= vec[2];
        top_vertical_phase_four_o <= vec[0];
      end
      horiz_storage_one_o <= h1s_nxt;
      horiz_barrier_one_o <= h1b_nxt;
      horiz_storage_two_o <= h2s_nxt;
      horiz_barrier_two_o <= h2b_nxt;
      last_horizontal_phase_o <= h2s_nxt; // RL9
      reset_gate_o <= rg_nxt;
    end
  end

  // status; pixel strobe lines up with the phase two fall at the pins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      p6_d_r <= 1'b0;
      pixel_strobe_o <= 1'b0;
      line_strobe_o <= 1'b0;
      frame_busy_o <= 1'b0;
    end else begin
      p6_d_r <= p6;
      pixel_strobe_o <= p6_d_r & ~p6; // RL7
      line_strobe_o <= (st_r == ST_HREAD) && (hcnt_r == HLAST) && (pix_r == pix_of(mode_r));
      frame_busy_o <= (st_r != ST_IDLE);
    end
  end

  sequence s_third_drop;
    $fell(bottom_phase_one_third_o);
  endsequence

  sequence s_ph4_rise;
    $rose(bottom_vertical_phase_four_o);
  endsequence

  chk_third_ph4_edge: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL6
    s_third_drop |-> s_ph4_rise)
    else $error("phase four rise not aligned with third level drop");

  chk_rise_with_fall: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL5
    ($rose(bottom_vertical_phase_two_o) || $rose(bottom_vertical_phase_three_o) ||
     $rose(bottom_vertical_phase_four_o)) |->
    ($fell(bottom_vertical_phase_one_o) || $fell(bottom_vertical_phase_two_o) ||
     $fell(bottom_vertical_phase_three_o) || $fell(bottom_vertical_phase_four_o)))
    else $error("vertical rise without matching fall");

  chk_line_count: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL4
    (st_r == ST_HREAD && hcnt_r == HLAST && pix_r == pix_of(mode_r) && line_r == lines_of(mode_r))
    |=> (st_r == ST_IDLE) ##1 !frame_busy_o)
    else $error("frame did not end after last line");

  chk_pix_count: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL8
    $rose(line_strobe_o) |-> $past(pix_r) == pix_of(mode_r))
    else $error("line ended at wrong pixel count");

  chk_last_follows: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL9
    last_horizontal_phase_o == horiz_storage_two_o)
    else $error("last phase differs from storage two");

  chk_park_level: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL11
    (park_r && $stable(park_r) && mode_r == MODE_SINGLE) |=>
    (horiz_storage_one_o[REG_C] && horiz_storage_two_o[REG_D] && reset_gate_o[REG_B]))
    else $error("parked lane not at off level");

  chk_slow_toggle: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL10
    !slow_en |=> $stable(slow_ph_r))
    else $error("slow lane toggled without divider enable");

  chk_top_remap: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL12
    (mode_r == MODE_DUAL_AB && $stable(mode_r)) |=> top_vertical_phase_two_o == bottom_vertical_phase_four_o)
    else $error("top phase two not remapped");

  chk_lane_a_map: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL1
    ##1 (horiz_storage_one_o[REG_A] == $past(p5) && reset_gate_o[REG_A] == $past(p7)))
    else $error("register a lane not on base pattern");
endmodule // ccdseq_timing_gen
